// [timer_consts.vh]
// constants for the timer compare and capture block
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CMP_HIGH 8'h08
`define ADDR_CMP_LOW 8'h0C
`define ADDR_COUNTER 8'h10
`define ADDR_CAP_HIGH 8'h14
`define ADDR_CAP_LOW 8'h18
`define ADDR_IRQ_MASK 8'h1C
`define CTRL_CLK_SEL_LSB 0
`define CTRL_EXT_BIT 2
`define CTRL_PIN_EN_BIT 3
`define CTRL_LEVEL_BIT 4
`define CTRL_CAP_FALL_BIT 5
`define CTRL_RESET 8'h00
`define ST_CMP_BIT 0
`define ST_CAP_BIT 1
`define ST_OVF_BIT 2
`define CMP_RESET 16'hFFFF
`define CNT_RESET 16'hFFFC
`define CNT_MAX 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [tick_gen.v]
// timer tick source: prescaled core clock or external clock edges
`timescale 1ns/1ps
module tick_gen (
  input wire core_clk,
  input wire sys_rst,
  input wire [1:0] clk_sel,
  input wire ext_sel,
  input wire ext_clk_pin,
  output reg tick
);
  reg [2:0] div_q;
  reg [2:0] ext_sync_q;
  wire [2:0] div_last;
  assign div_last = (clk_sel == 2'h0) ? 3'h1 : (clk_sel == 2'h1) ? 3'h3 : 3'h7;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= 3'h0;
      ext_sync_q <= 3'h0;
      tick <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_pin};
      if (ext_sel) begin
        div_q <= 3'h0;
        tick <= ext_sync_q[1] & ~ext_sync_q[2];
      end else if (div_q >= div_last) begin
        div_q <= 3'h0;
        tick <= 1'b1;
      end else begin
        div_q <= div_q + 3'h1;
        tick <= 1'b0;
      end
    end
  end
endmodule // tick_gen

// [capture_unit.v]
// capture input synchroniser, edge detect and latch
`timescale 1ns/1ps
module capture_unit (
  input wire core_clk,
  input wire sys_rst,
  input wire capture_input_pin,
  input wire fall_edge,
  input wire disarm,
  input wire rearm,
  input wire [15:0] counter,
  output reg [15:0] capture_value,
  output reg capture_event
);
  reg [2:0] sync_q;
  reg armed_q;
  wire edge_seen;
  wire take_edge;
  // rising edge by default, falling when selected
  assign edge_seen = fall_edge ? (sync_q[2] & ~sync_q[1]) : (sync_q[1] & ~sync_q[2]);
  assign take_edge = edge_seen & armed_q & ~disarm;
  // event straight from the detector: a registered event would add a third clock of delay
  always @* begin
    capture_event = take_edge;
  end
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sync_q <= 3'h0;
      armed_q <= 1'b1;
      capture_value <= 16'h0000;
    end else begin
      sync_q <= {sync_q[1:0], capture_input_pin};
      if (disarm) begin
        armed_q <= 1'b0;
      end else if (rearm) begin
        armed_q <= 1'b1;
      end
      if (take_edge) begin
        capture_value <= counter;
      end
    end
  end
endmodule // capture_unit

// [timer_output_compare.v]
// timer compare/capture block with axi4-lite register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "timer_consts.vh"
module timer_output_compare (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_clk_pin,
  input wire capture_input_pin,
  output reg compare_output_pin,
  output reg compare_output_oe,
  output reg irq
);
  reg [7:0] ctrl_q;
  reg [2:0] mask_q;
  reg [2:0] status_q;
  reg [15:0] counter_q;
  reg [15:0] compare_value_q;
  reg cmp_inhibit_q;
  reg cmp_armed_clear_q;
  reg [7:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  wire tick;
  wire [15:0] capture_value;
  wire capture_event;
  wire do_write;
  wire do_read;
  wire [7:0] rd_addr;
  wire cmp_match;
  wire cnt_wrap;
  wire low_access;
  wire cap_high_read;
  wire cap_low_read;
  reg [31:0] rd_mux;
  reg rd_ok;

  // decoding used by both the read and write paths
  function addr_is;
    input [7:0] a;
    input [7:0] ref_addr;
    begin
      addr_is = (a[7:2] == ref_addr[7:2]);
    end
  endfunction

  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a[7:2] <= `ADDR_IRQ_MASK >> 2);
    end
  endfunction

  tick_gen u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_sel(ctrl_q[`CTRL_CLK_SEL_LSB+1:`CTRL_CLK_SEL_LSB]),
    .ext_sel(ctrl_q[`CTRL_EXT_BIT]),
    .ext_clk_pin(ext_clk_pin),
    .tick(tick)
  );

  // capture runs on its own path, untouched by compare state
  capture_unit u_cap (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .capture_input_pin(capture_input_pin),
    .fall_edge(ctrl_q[`CTRL_CAP_FALL_BIT]),
    .disarm(cap_high_read),
    .rearm(cap_low_read),
    .counter(counter_q),
    .capture_value(capture_value),
    .capture_event(capture_event)
  );

  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign do_read = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign low_access = (do_write & addr_is(aw_addr_q, `ADDR_CMP_LOW)) |
    (do_read & addr_is(rd_addr, `ADDR_CMP_LOW));
  assign cap_high_read = do_read & addr_is(rd_addr, `ADDR_CAP_HIGH);
  assign cap_low_read = do_read & addr_is(rd_addr, `ADDR_CAP_LOW);
  // match holds while counter equals compare and no high byte write awaits its low byte, whichever clock source
  assign cmp_match = (counter_q == compare_value_q) & ~cmp_inhibit_q;
  assign cnt_wrap = tick & (counter_q == `CNT_MAX);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      counter_q <= `CNT_RESET;
    end else if (tick) begin
      counter_q <= counter_q + 16'h0001;
    end
  end

  // write address and data taken independently, response after both
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register writes; byte lane 0 carries every field
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RESET;
      mask_q <= 3'h0;
      compare_value_q <= `CMP_RESET;
      cmp_inhibit_q <= 1'b0;
    end else if (do_write & w_strb_q[0]) begin
      if (addr_is(aw_addr_q, `ADDR_CTRL)) begin
        ctrl_q <= w_data_q[7:0];
      end
      if (addr_is(aw_addr_q, `ADDR_IRQ_MASK)) begin
        mask_q <= w_data_q[2:0];
      end
      if (addr_is(aw_addr_q, `ADDR_CMP_HIGH)) begin
        compare_value_q[15:8] <= w_data_q[7:0];
        cmp_inhibit_q <= 1'b1;
      end
      if (addr_is(aw_addr_q, `ADDR_CMP_LOW)) begin
        compare_value_q[7:0] <= w_data_q[7:0];
        cmp_inhibit_q <= 1'b0;
      end
    end
  end

  // compare flag: status read while set arms the clear, low access completes it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      status_q <= 3'h0;
      cmp_armed_clear_q <= 1'b0;
    end else begin
      if (do_read & addr_is(rd_addr, `ADDR_STATUS) & status_q[`ST_CMP_BIT]) begin
        cmp_armed_clear_q <= 1'b1;
      end else if (low_access) begin
        cmp_armed_clear_q <= 1'b0;
      end
      // set wins over any clear in the same cycle
      if (cmp_match) begin
        status_q[`ST_CMP_BIT] <= 1'b1;
      end else if (low_access & cmp_armed_clear_q) begin
        status_q[`ST_CMP_BIT] <= 1'b0;
      end
      if (capture_event) begin
        status_q[`ST_CAP_BIT] <= 1'b1;
      end else if (do_read & addr_is(rd_addr, `ADDR_STATUS)) begin
        status_q[`ST_CAP_BIT] <= 1'b0;
      end
      if (cnt_wrap) begin
        status_q[`ST_OVF_BIT] <= 1'b1;
      end else if (do_read & addr_is(rd_addr, `ADDR_STATUS)) begin
        status_q[`ST_OVF_BIT] <= 1'b0;
      end
    end
  end

  // pin drives only when enabled; level loaded on match while enabled
  always @(posedge core_clk) begin
    if (sys_rst) begin
      compare_output_pin <= 1'b0;
      compare_output_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      compare_output_oe <= ctrl_q[`CTRL_PIN_EN_BIT];
      if (cmp_match & ctrl_q[`CTRL_PIN_EN_BIT]) begin
        compare_output_pin <= ctrl_q[`CTRL_LEVEL_BIT];
      end
      irq <= |(status_q & mask_q);
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = addr_mapped(rd_addr);
    case ({2'h0, rd_addr[7:2]})
      `ADDR_CTRL >> 2: rd_mux = {24'h000000, ctrl_q};
      `ADDR_STATUS >> 2: rd_mux = {29'h0, status_q};
      `ADDR_CMP_HIGH >> 2: rd_mux = {24'h000000, compare_value_q[15:8]};
      `ADDR_CMP_LOW >> 2: rd_mux = {24'h000000, compare_value_q[7:0]};
      `ADDR_COUNTER >> 2: rd_mux = {16'h0000, counter_q};
      `ADDR_CAP_HIGH >> 2: rd_mux = {24'h000000, capture_value[15:8]};
      `ADDR_CAP_LOW >> 2: rd_mux = {24'h000000, capture_value[7:0]};
      `ADDR_IRQ_MASK >> 2: rd_mux = {29'h0, mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // timer_output_compare

// [timer_output_compare_props.sv]
// port assertions for the timer compare and capture block
`timescale 1ns/1ps
`include "timer_consts.vh"
module timer_output_compare_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic mask_wr_q;
  logic oe_exp_q;
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  wire rd_take = s_axi_arvalid && s_axi_arready;
  // until software writes the mask every source stays masked
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mask_wr_q <= 1'b0;
      oe_exp_q <= 1'b0;
    end else if (wr_take) begin
      if (s_axi_awaddr == `ADDR_IRQ_MASK) mask_wr_q <= 1'b1;
      if (s_axi_awaddr == `ADDR_CTRL) oe_exp_q <= s_axi_wdata[`CTRL_PIN_EN_BIT];
    end
  end
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_B_ANSWER: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_R_ANSWER: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_SLVERR: assert property (rd_take && s_axi_araddr[7:2] > (`ADDR_IRQ_MASK >> 2) |=> s_axi_rresp == `RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_OE_FOLLOW: assert property (wr_take && s_axi_awaddr == `ADDR_CTRL |-> ##3 compare_output_oe == oe_exp_q)
    else $error("pin enable not followed");
  AST_PIN_QUIET: assert property (!compare_output_oe && $past(!compare_output_oe) |-> $stable(compare_output_pin))
    else $error("disabled pin changed");
  AST_IRQ_MASKED: assert property (!mask_wr_q |-> !irq)
    else $error("irq while all masked");
  cover property (wr_take);
  cover property (rd_take);
  cover property ($rose(irq));
  cover property ($rose(compare_output_oe));
endmodule // timer_output_compare_props
bind timer_output_compare timer_output_compare_props i_props (.*);

// [timer_output_compare_test.sv]
// self-checking testbench for the timer compare and capture block
`timescale 1ns/1ps
`include "timer_consts.vh"
module timer_output_compare_test;
  logic core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_clk_pin, capture_input_pin, compare_output_pin, compare_output_oe, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
  logic [15:0] t;
  int failures, checks, cyc;
  timer_output_compare i_dut (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // external timer clock: 8 core cycles per period, only the tick rate matters here
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) ext_clk_pin <= ~ext_clk_pin;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // the write response ends this wait, or else the bench timeout
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        bresp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_q = s_axi_rdata;
        rresp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  // high first, status read, then low: no stale flag survives the rearm
  task automatic arm();
    rd(`ADDR_COUNTER);
    t = rd_q[15:0] + 16'h0028;
    wr(`ADDR_CMP_HIGH, {24'h0, t[15:8]});
    rd(`ADDR_STATUS);
    wr(`ADDR_CMP_LOW, {24'h0, t[7:0]});
    repeat (100) @(posedge core_clk);
  endtask
  task automatic t_reset_flags();
    chk("irq", 0, irq);
    repeat (20) @(posedge core_clk);
    rd(`ADDR_STATUS);
    chk("status", 5, rd_q[2:0]);
    chk("rresp", `RESP_OKAY, rresp_q);
    rd(`ADDR_STATUS);
    chk("status", 1, rd_q[2:0]);
    rd(`ADDR_CMP_LOW);
    rd(`ADDR_STATUS);
    chk("status", 0, rd_q[2:0]);
    rd(8'h20);
    chk("rresp", `RESP_SLVERR, rresp_q);
    wr(8'h20, 32'hFF);
    chk("bresp", `RESP_SLVERR, bresp_q);
  endtask
  task automatic t_rate();
    logic [15:0] c0, d, e;
    // code 4 selects the external clock; the span is 64 cycles between samples
    for (int i = 0; i < 5; i++) begin
      e = (i == 0) ? 16'h0020 : (i == 1) ? 16'h0010 : 16'h0008;
      wr(`ADDR_CTRL, i);
      rd(`ADDR_COUNTER);
      c0 = rd_q[15:0];
      repeat (61) @(posedge core_clk);
      rd(`ADDR_COUNTER);
      d = rd_q[15:0] - c0;
      chk("rate", e, (d + 16'h0001 - e <= 16'h0002) ? e : d);
    end
  endtask
  task automatic t_compare();
    wr(`ADDR_CTRL, 32'h18);
    chk("bresp", `RESP_OKAY, bresp_q);
    rd(`ADDR_COUNTER);
    t = rd_q[15:0] + 16'h0028;
    wr(`ADDR_CMP_HIGH, {24'h0, t[15:8]});
    wr(`ADDR_CMP_LOW, {24'h0, t[7:0]});
    wr(`ADDR_CMP_HIGH, {24'h0, t[15:8]});
    repeat (100) @(posedge core_clk);
    rd(`ADDR_STATUS);
    chk("cmp_flag", 0, rd_q[0]);
    chk("pin", 0, compare_output_pin);
    chk("oe", 1, compare_output_oe);
    arm();
    rd(`ADDR_STATUS);
    chk("cmp_flag", 1, rd_q[0]);
    chk("pin", 1, compare_output_pin);
    wr(`ADDR_CTRL, 32'h0);
    @(posedge core_clk);
    chk("oe", 0, compare_output_oe);
    arm();
    rd(`ADDR_STATUS);
    chk("cmp_flag", 1, rd_q[0]);
    chk("pin", 1, compare_output_pin);
    wr(`ADDR_IRQ_MASK, 32'h1);
    @(posedge core_clk);
    chk("irq", 1, irq);
  endtask
  task automatic t_capture();
    int n;
    wr(`ADDR_IRQ_MASK, 32'h2);
    rd(`ADDR_STATUS);
    chk("irq", 0, irq);
    @(posedge core_clk);
    capture_input_pin <= 1'b1;
    for (n = 1; n < 10; n++) begin
      @(posedge core_clk);
      if (irq === 1'b1) break;
    end
    chk("cap_delay", 1, n >= 4 && n <= 5);
    rd(`ADDR_STATUS);
    chk("cap_flag", 1, rd_q[1]);
    rd(`ADDR_CAP_HIGH);
    capture_input_pin <= 1'b0;
    repeat (5) @(posedge core_clk);
    capture_input_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`ADDR_STATUS);
    chk("cap_flag", 0, rd_q[1]);
    rd(`ADDR_CAP_LOW);
    capture_input_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(`ADDR_STATUS);
    chk("cap_flag", 0, rd_q[1]);
    capture_input_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`ADDR_STATUS);
    chk("cap_flag", 1, rd_q[1]);
    // falling edge selected: the pin going low now captures
    wr(`ADDR_CTRL, 32'h20);
    capture_input_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(`ADDR_STATUS);
    chk("cap_flag", 1, rd_q[1]);
    wr(`ADDR_IRQ_MASK, 32'h0);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {ext_clk_pin, capture_input_pin, failures, checks, cyc} = 0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset_flags();
    t_rate();
    t_compare();
    t_capture();
    finish_test();
  end
endmodule // timer_output_compare_test
